// ==== design/jtbs_tap.sv ====
// Test access port with instruction decode and 134-bit boundary register
// Operation
// - Test access uses exactly four pins: test clock, mode, data in, data out.
// - Scans follow the standard TAP state sequence driven by the controller.
// - Instruction register is 16 bits; decode uses the full value.
// - Value 0x0000 selects boundary register with pin control and observation.
// - Value 0x0002 selects boundary register for sampling and preload, no driving.
// - Value 0x0004 places the identification register between data in and out.
// - Value 0xFFFF selects the one-bit bypass register.
// - Value 0x0082 selects the flash control register.
// - Value 0x0083 selects the flash data register.
// - Value 0x0084 selects the flash address register.
// - Value 0x0085 selects the flash scale register.
// - Three boundary-scan data registers and four flash data registers exist.
// - Boundary register is a 134-bit shift chain over pins and pullup.
// - EXTEST captures and updates; SAMPLE captures and preloads the update latches but never drives pins.
// - Small package: bit 0 reset enable, bit 1 reset pin data.
// - Large package: bit 2 reset enable, bit 3 reset pin data.
// - Bit 4 captures the crystal input; its update does nothing.
// - Bit 5 captures and drives the weak pullup enable.
// - Port 0 even bits 6-20 output enables, odd bits 7-21 data.
// - Ports 1-7 repeat in 16-bit groups from bit 22 up to 133.
// - Identification register is 32 bits wide.
// - During EXTEST all inputs to on-chip logic read as logic 1.
`include "jtbs_consts.svh"
module jtbs_tap
  import jtbs_pkg::*;
#(
  parameter logic [31:0] ID_CODE    = 32'h0000_0001, // Arbitrary identity value
  parameter bit          LARGE_PKG  = 1'b1
)(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Test pins
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdoOe,
  // Pin side
  input  wire logic                  rstPinIn,
  output logic                       rstPinOut,
  output logic                       rstPinOe,
  input  wire logic                  crystalInputPin,
  output logic                       weakPullupEn,
  input  wire logic [7:0]            portPinIn [`JTBS_NPORTS],
  output jtbs_port_t                 portPin [`JTBS_NPORTS],
  // Core side
  input  wire logic                  mcuRstEn,
  input  wire logic                  mcuRstOut,
  input  wire logic                  mcuWeakPullup,
  input  jtbs_port_t                 mcuPort [`JTBS_NPORTS],
  output logic                       coreRstIn,
  output logic                       coreClkIn,
  output logic [7:0]                 corePortIn [`JTBS_NPORTS],
  // Flash indirect register access
  output jtbs_sel_t                  irSelect,
  output logic                       flashUpdate,
  output logic [`JTBS_FLASH_W-1:0]   flashWrData,
  input  wire logic [`JTBS_FLASH_W-1:0] flashRdData
);

  function automatic jtbs_sel_t decodeIr(input logic [`JTBS_IR_W-1:0] ir);
    jtbs_sel_t s;
    s = SEL_BYPASS;
    if (ir == `JTBS_IR_EXTEST) s = SEL_BOUNDARY;
    else if (ir == `JTBS_IR_SAMPLE) s = SEL_BOUNDARY;
    else if (ir == `JTBS_IR_IDCODE) s = SEL_IDCODE;
    else if (ir == `JTBS_IR_BYPASS) s = SEL_BYPASS;
    else if (ir == `JTBS_IR_FCTL) s = SEL_FCTL;
    else if (ir == `JTBS_IR_FDAT) s = SEL_FDAT;
    else if (ir == `JTBS_IR_FADR) s = SEL_FADR;
    else if (ir == `JTBS_IR_FSCL) s = SEL_FSCL;
    return s;
  endfunction

  // Pin synchronisers; the test clock is sampled and its edges found here
  logic [1:0] tckSync_r, tmsSync_r, tdiSync_r;
  logic       tckLast_r;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tckSync_r <= 2'h0;
      tmsSync_r <= 2'h3;
      tdiSync_r <= 2'h0;
      tckLast_r <= 1'b0;
    end
    else
    begin
      tckSync_r <= {tckSync_r[0], tck};
      tmsSync_r <= {tmsSync_r[0], tms};
      tdiSync_r <= {tdiSync_r[0], tdi};
      tckLast_r <= tckSync_r[1];
    end
  end
  logic tckRise, tckFall, tmsS, tdiS;
  assign tckRise = tckSync_r[1] & ~tckLast_r;
  assign tckFall = ~tckSync_r[1] & tckLast_r;
  assign tmsS    = tmsSync_r[1];
  assign tdiS    = tdiSync_r[1];

  // TAP state machine
  jtbs_state_t state_r, state_nxt;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TLR:  state_nxt = tmsS ? TLR  : RTI;
      RTI:  state_nxt = tmsS ? SDRS : RTI;
      SDRS: state_nxt = tmsS ? SIRS : CDR;
      CDR:  state_nxt = tmsS ? E1DR : SDR;
      SDR:  state_nxt = tmsS ? E1DR : SDR;
      E1DR: state_nxt = tmsS ? UDR  : PDR;
      PDR:  state_nxt = tmsS ? E2DR : PDR;
      E2DR: state_nxt = tmsS ? UDR  : SDR;
      UDR:  state_nxt = tmsS ? SDRS : RTI;
      SIRS: state_nxt = tmsS ? TLR  : CIR;
      CIR:  state_nxt = tmsS ? E1IR : SIR;
      SIR:  state_nxt = tmsS ? E1IR : SIR;
      E1IR: state_nxt = tmsS ? UIR  : PIR;
      PIR:  state_nxt = tmsS ? E2IR : PIR;
      E2IR: state_nxt = tmsS ? UIR  : SIR;
      UIR:  state_nxt = tmsS ? SDRS : RTI;
      default: state_nxt = TLR;
    endcase
  end
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= TLR;
    else if (tckRise)
      state_r <= state_nxt;
  end

  // Instruction register
  logic [`JTBS_IR_W-1:0] irShift_r, ir_r;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irShift_r <= '0;
      ir_r      <= `JTBS_IR_IDCODE;
    end
    else if (tckRise)
    begin
      if (state_r == TLR)
        ir_r <= `JTBS_IR_IDCODE;
      else if (state_r == CIR)
        irShift_r <= `JTBS_IR_CAPTURE;
      else if (state_r == SIR)
        irShift_r <= {tdiS, irShift_r[`JTBS_IR_W-1:1]};
      else if (state_r == UIR)
        ir_r <= irShift_r;
    end
  end
  jtbs_sel_t sel;
  logic      extest;
  assign sel      = decodeIr(ir_r);
  assign extest   = (ir_r == `JTBS_IR_EXTEST);
  assign irSelect = sel;

  // Capture vector for the boundary chain
  logic [`JTBS_BSR_LEN-1:0] bsrCap;
  always_comb
  begin
    bsrCap = '0;
    bsrCap[LARGE_PKG ? `JTBS_BIT_RSTEN_L : `JTBS_BIT_RSTEN_S] = mcuRstEn;
    bsrCap[LARGE_PKG ? `JTBS_BIT_RSTIO_L : `JTBS_BIT_RSTIO_S] = rstPinIn;
    bsrCap[`JTBS_BIT_XTAL] = crystalInputPin;
    bsrCap[`JTBS_BIT_WPU]  = mcuWeakPullup;
    for (int p = 0; p < `JTBS_NPORTS; p++)
      for (int b = 0; b < 8; b++)
      begin
        bsrCap[`JTBS_BIT_PORT0 + p*`JTBS_PORT_BITS + 2*b]     = mcuPort[p].oe[b];
        bsrCap[`JTBS_BIT_PORT0 + p*`JTBS_PORT_BITS + 2*b + 1] = portPinIn[p][b];
      end
  end

  // Data registers: shift on rising test clock, update latches as well
  logic [`JTBS_BSR_LEN-1:0] bsr_r, bsrUpd_r;
  logic [`JTBS_ID_W-1:0]    id_r;
  logic                     byp_r;
  logic [`JTBS_FLASH_W-1:0] flash_r;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bsr_r    <= '0;
      bsrUpd_r <= '0;
      id_r     <= '0;
      byp_r    <= 1'b0;
      flash_r  <= '0;
    end
    else if (tckRise)
    begin
      if (state_r == CDR)
      begin
        bsr_r   <= bsrCap;
        id_r    <= ID_CODE;
        byp_r   <= 1'b0;
        flash_r <= flashRdData;
      end
      else if (state_r == SDR)
      begin
        case (sel)
          SEL_BOUNDARY: bsr_r <= {tdiS, bsr_r[`JTBS_BSR_LEN-1:1]};
          SEL_IDCODE:   id_r  <= {tdiS, id_r[`JTBS_ID_W-1:1]};
          SEL_BYPASS:   byp_r <= tdiS;
          default:      flash_r <= {tdiS, flash_r[`JTBS_FLASH_W-1:1]};
        endcase
      end
      else if (state_r == UDR && sel == SEL_BOUNDARY)
        bsrUpd_r <= bsr_r;
    end
  end

  // Flash indirect write strobe
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flashUpdate <= 1'b0;
      flashWrData <= '0;
    end
    else
    begin
      flashUpdate <= tckRise && state_r == UDR && sel inside {SEL_FCTL, SEL_FDAT,
                     SEL_FADR, SEL_FSCL};
      if (tckRise && state_r == UDR)
        flashWrData <= flash_r;
    end
  end

  // TDO changes on the falling test clock
  logic tdoBit;
  always_comb
  begin
    tdoBit = byp_r;
    if (state_r == SIR) tdoBit = irShift_r[0];
    else if (sel == SEL_BOUNDARY) tdoBit = bsr_r[0];
    else if (sel == SEL_IDCODE) tdoBit = id_r[0];
    else if (sel != SEL_BYPASS) tdoBit = flash_r[0];
  end
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end
    else if (tckFall)
    begin
      tdo   <= tdoBit;
      tdoOe <= (state_r == SDR) || (state_r == SIR);
    end
  end

  // Pin and core muxing; only EXTEST lets the update latches reach pins
  localparam int EnB = LARGE_PKG ? `JTBS_BIT_RSTEN_L : `JTBS_BIT_RSTEN_S;
  localparam int IoB = LARGE_PKG ? `JTBS_BIT_RSTIO_L : `JTBS_BIT_RSTIO_S;
  assign rstPinOe     = extest ? bsrUpd_r[EnB] : mcuRstEn;
  assign rstPinOut    = extest ? bsrUpd_r[IoB] : mcuRstOut;
  assign weakPullupEn = extest ? bsrUpd_r[`JTBS_BIT_WPU] : mcuWeakPullup;
  assign coreRstIn    = extest | rstPinIn;
  assign coreClkIn    = extest | crystalInputPin;
  genvar gp, gb;
  generate
    for (gp = 0; gp < `JTBS_NPORTS; gp++)
    begin : g_port
      for (gb = 0; gb < 8; gb++)
      begin : g_bit
        assign portPin[gp].oe[gb]   = extest ?
          bsrUpd_r[`JTBS_BIT_PORT0 + gp*`JTBS_PORT_BITS + 2*gb] : mcuPort[gp].oe[gb];
        assign portPin[gp].dout[gb] = extest ?
          bsrUpd_r[`JTBS_BIT_PORT0 + gp*`JTBS_PORT_BITS + 2*gb + 1] : mcuPort[gp].dout[gb];
        assign corePortIn[gp][gb]   = extest | portPinIn[gp][gb];
      end
    end
  endgenerate

  // Checks
  property p_sample_no_drive;
    @(posedge ref_clk) disable iff (sys_rst)
    (ir_r == `JTBS_IR_SAMPLE) |-> (portPin[0].oe == mcuPort[0].oe);
  endproperty
  a_sample_no_drive: assert property (p_sample_no_drive) else $error("pins driven");

  property p_extest_ones;
    @(posedge ref_clk) disable iff (sys_rst)
    extest |-> (corePortIn[3] == 8'hFF && coreRstIn);
  endproperty
  a_extest_ones: assert property (p_extest_ones) else $error("core input not one");

  property p_undef_bypass;
    @(posedge ref_clk) disable iff (sys_rst)
    (ir_r == 16'h0001) |-> (sel == SEL_BYPASS);
  endproperty
  a_undef_bypass: assert property (p_undef_bypass) else $error("bad default select");

  property p_tlr_exit;
    @(posedge ref_clk) disable iff (sys_rst)
    (tckRise && state_r == TLR && !tmsS) |=> (state_r == RTI);
  endproperty
  a_tlr_exit: assert property (p_tlr_exit) else $error("tap did not leave reset");

  property p_ir_update;
    @(posedge ref_clk) disable iff (sys_rst)
    (tckRise && state_r == UIR) |=> (ir_r == $past(irShift_r));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir not updated");

  property p_idcode_cap;
    @(posedge ref_clk) disable iff (sys_rst)
    (tckRise && state_r == CDR) |=> (id_r == ID_CODE);
  endproperty
  a_idcode_cap: assert property (p_idcode_cap) else $error("id not captured");

  property p_flash_strobe;
    @(posedge ref_clk) disable iff (sys_rst)
    flashUpdate |-> (sel == SEL_FCTL || sel == SEL_FDAT || sel == SEL_FADR || sel == SEL_FSCL);
  endproperty
  a_flash_strobe: assert property (p_flash_strobe) else $error("stray flash strobe");

  property p_xtal_cap;
    @(posedge ref_clk) disable iff (sys_rst)
    (tckRise && state_r == CDR) |=> (bsr_r[`JTBS_BIT_XTAL] == $past(crystalInputPin));
  endproperty
  a_xtal_cap: assert property (p_xtal_cap) else $error("crystal bit wrong");
endmodule

// ==== design/jtbs_consts.svh ====
// Constants for the test access port and boundary register
`ifndef JTBS_CONSTS_SVH
`define JTBS_CONSTS_SVH
`define JTBS_IR_W        16
`define JTBS_IR_EXTEST   16'h0000
`define JTBS_IR_SAMPLE   16'h0002
`define JTBS_IR_IDCODE   16'h0004
`define JTBS_IR_BYPASS   16'hFFFF
`define JTBS_IR_FCTL     16'h0082
`define JTBS_IR_FDAT     16'h0083
`define JTBS_IR_FADR     16'h0084
`define JTBS_IR_FSCL     16'h0085
`define JTBS_IR_CAPTURE  16'h0001
`define JTBS_BSR_LEN     134
`define JTBS_ID_W        32
`define JTBS_FLASH_W     20
`define JTBS_BIT_RSTEN_S 0
`define JTBS_BIT_RSTIO_S 1
`define JTBS_BIT_RSTEN_L 2
`define JTBS_BIT_RSTIO_L 3
`define JTBS_BIT_XTAL    4
`define JTBS_BIT_WPU     5
`define JTBS_BIT_PORT0   6
`define JTBS_PORT_BITS   16
`define JTBS_NPORTS      8
`endif

// ==== design/jtbs_pkg.sv ====
// Types for the test access port and boundary register
package jtbs_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SDRS = 4'h3, CDR = 4'h2, SDR = 4'h6, E1DR = 4'h7,
    PDR = 4'h5, E2DR = 4'h4, UDR = 4'hC, SIRS = 4'hD, CIR = 4'hF, SIR = 4'hE,
    E1IR = 4'hA, PIR = 4'hB, E2IR = 4'h9, UIR = 4'h8
  } jtbs_state_t;
  typedef enum logic [2:0] {
    SEL_BOUNDARY, SEL_IDCODE, SEL_BYPASS, SEL_FCTL, SEL_FDAT, SEL_FADR, SEL_FSCL
  } jtbs_sel_t;
  // Per-port pin view
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dout;
  } jtbs_port_t;
endpackage

// ==== test/jtbs_ctrl_model.sv ====
// Behavioural test controller that drives three test pins and samples data out
module jtbs_ctrl_model (
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Clock only runs inside a step, so it stands still between scans
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    o = tdo;
    #80 tck = 1'b0;
  endtask
  task automatic goIdle();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Starts and ends in Run-Test-Idle; shifts LSB first
  task automatic scan(input bit isIr, input logic [133:0] din, input int n,
                      output logic [133:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (isIr)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the test access port and boundary register
`include "jtbs_consts.svh"
module testbench
  import jtbs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0]  TestId = 32'h0F0F_3C3C; // Arbitrary value
  localparam logic [133:0] Pat    = {2'h2, {11{12'h6B9}}};
  typedef struct {
    logic [15:0] ir;
    jtbs_sel_t   sel;
  } jtbs_row_t;
  jtbs_row_t rows [11] = '{
    '{16'h0000, SEL_BOUNDARY}, '{16'h0002, SEL_BOUNDARY}, '{16'h0004, SEL_IDCODE},
    '{16'hFFFF, SEL_BYPASS}, '{16'h0082, SEL_FCTL}, '{16'h0083, SEL_FDAT},
    '{16'h0084, SEL_FADR}, '{16'h0085, SEL_FSCL}, '{16'h0001, SEL_BYPASS},
    '{16'h0104, SEL_BYPASS}, '{16'h8082, SEL_BYPASS}};
  logic         ref_clk, sys_rst, tck, tms, tdi, tdo, tdoOe, flashUpdate;
  logic         rstPinIn, rstPinOut, rstPinOe, crystalInputPin, weakPullupEn;
  logic         mcuRstEn, mcuRstOut, mcuWeakPullup, coreRstIn, coreClkIn;
  logic [7:0]   portPinIn [`JTBS_NPORTS];
  logic [7:0]   corePortIn [`JTBS_NPORTS];
  jtbs_port_t   portPin [`JTBS_NPORTS];
  jtbs_port_t   mcuPort [`JTBS_NPORTS];
  jtbs_sel_t    irSelect;
  logic [19:0]  flashWrData, flashRdData;
  logic [133:0] got;
  logic         smRstOe, smRstOut;
  int           miscompares, numChecks, pulses, base, oeCycles;

  jtbs_tap #(.ID_CODE(TestId), .LARGE_PKG(1'b1)) dut (
    .ref_clk, .sys_rst, .tck, .tms, .tdi, .tdo, .tdoOe, .rstPinIn, .rstPinOut,
    .rstPinOe, .crystalInputPin, .weakPullupEn, .portPinIn, .portPin, .mcuRstEn,
    .mcuRstOut, .mcuWeakPullup, .mcuPort, .coreRstIn, .coreClkIn, .corePortIn,
    .irSelect, .flashUpdate, .flashWrData, .flashRdData);
  jtbs_ctrl_model ctrl (.tck, .tms, .tdi, .tdo);
  // Small package wiring; only its reset pin pair is watched
  jtbs_tap #(.ID_CODE(TestId), .LARGE_PKG(1'b0)) dutSmall (
    .ref_clk, .sys_rst, .tck, .tms, .tdi, .tdo(), .tdoOe(), .rstPinIn,
    .rstPinOut(smRstOut), .rstPinOe(smRstOe), .crystalInputPin, .weakPullupEn(),
    .portPinIn, .portPin(), .mcuRstEn, .mcuRstOut, .mcuWeakPullup, .mcuPort,
    .coreRstIn(), .coreClkIn(), .corePortIn(), .irSelect(), .flashUpdate(),
    .flashWrData(), .flashRdData);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (flashUpdate === 1'b1)
      pulses <= pulses + 1;
    if (tdoOe === 1'b1)
      oeCycles <= oeCycles + 1;
  end

  task automatic chkBits(input logic [133:0] g, input logic [133:0] e);
    numChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkSel(input jtbs_sel_t g, input jtbs_sel_t e);
    chkBits(134'(g), 134'(e));
  endtask
  task automatic summarize();
    if (miscompares == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Aligns every scan just after a falling clock edge, off the sampling edge
  task automatic runScan(input bit isIr, input logic [133:0] din, input int n);
    @(negedge ref_clk);
    #1 ctrl.scan(isIr, din, n, got);
  endtask
  task automatic setIn(input bit k);
    rstPinIn        = k;
    crystalInputPin = ~k;
    mcuRstEn        = k;
    mcuRstOut       = ~k;
    mcuWeakPullup   = k;
    foreach (mcuPort[p])
    begin
      mcuPort[p]   = '{8'h5A ^ 8'(p) ^ {8{k}}, 8'hC3 ^ 8'(p * 16)};
      portPinIn[p] = 8'h96 ^ 8'(p * 9) ^ {8{k}};
    end
  endtask
  // Unused small-package reset pair captures zero
  function automatic logic [133:0] capExp();
    logic [133:0] e;
    e    = '0;
    e[2] = mcuRstEn;
    e[3] = rstPinIn;
    e[4] = crystalInputPin;
    e[5] = mcuWeakPullup;
    for (int p = 0; p < 8; p++)
      for (int n = 0; n < 8; n++)
      begin
        e[6 + 16 * p + 2 * n] = mcuPort[p].oe[n];
        e[7 + 16 * p + 2 * n] = portPinIn[p][n];
      end
    return e;
  endfunction
  task automatic chkPins(input bit drv, input logic [133:0] v);
    logic [15:0] ep;
    chkBits(134'(rstPinOe), 134'(drv ? v[2] : mcuRstEn));
    chkBits(134'(rstPinOut), 134'(drv ? v[3] : mcuRstOut));
    chkBits(134'(weakPullupEn), 134'(drv ? v[5] : mcuWeakPullup));
    chkBits(134'(coreRstIn), 134'(drv | rstPinIn));
    chkBits(134'(coreClkIn), 134'(drv | crystalInputPin));
    chkBits(134'(tdoOe), 134'h0);
    chkBits(134'(smRstOe), 134'(drv ? v[0] : mcuRstEn));
    chkBits(134'(smRstOut), 134'(drv ? v[1] : mcuRstOut));
    for (int p = 0; p < 8; p++)
    begin
      ep = mcuPort[p];
      for (int n = 0; n < 8; n++)
        if (drv)
          {ep[8 + n], ep[n]} = {v[6 + 16 * p + 2 * n], v[7 + 16 * p + 2 * n]};
      chkBits(134'(portPin[p]), 134'(ep));
      chkBits(134'(corePortIn[p]), 134'(drv ? 8'hFF : portPinIn[p]));
    end
  endtask

  initial
  begin
    #400000;
    miscompares++;
    summarize();
  end

  initial
  begin
    sys_rst     = 1'b1;
    flashRdData = 20'h0;
    setIn(1'b0);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chkSel(irSelect, SEL_IDCODE);
    chkPins(1'b0, Pat);
    #1 ctrl.goIdle();
    foreach (rows[i])
    begin
      runScan(1'b1, 134'(rows[i].ir), 16);
      chkBits(got, 134'h1);
      chkSel(irSelect, rows[i].sel);
    end
    runScan(1'b1, 134'h4, 16);
    base = oeCycles;
    runScan(1'b0, '0, 32);
    chkBits(got, 134'(TestId));
    // Data out is enabled for 32 shifts of 40 system cycles each
    chkBits(134'(oeCycles - base), 134'h500);
    runScan(1'b1, 134'hFFFF, 16);
    runScan(1'b0, 134'hA5, 8);
    chkBits(got, 134'h4A);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge ref_clk) flashRdData = 20'h5A3C0 + 20'(k);
      runScan(1'b1, 134'(16'h0082 + 16'(k)), 16);
      base = pulses;
      runScan(1'b0, 134'(20'hC3A90 + 20'(k)), 20);
      chkBits(got, 134'(flashRdData));
      chkBits(134'(flashWrData), 134'(20'hC3A90 + 20'(k)));
      chkBits(134'(pulses - base), 134'h1);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(negedge ref_clk) setIn(k[0]);
      runScan(1'b1, 134'h2, 16);
      runScan(1'b0, Pat ^ {134{k[0]}}, 134);
      chkBits(got, capExp());
      chkPins(1'b0, Pat);
    end
    runScan(1'b1, 134'h0, 16);
    runScan(1'b0, Pat ^ 134'h3, 134);
    chkBits(got, capExp());
    chkPins(1'b1, Pat ^ 134'h3);
    @(negedge ref_clk) sys_rst = 1'b1;
    @(negedge ref_clk) sys_rst = 1'b0;
    @(negedge ref_clk);
    chkSel(irSelect, SEL_IDCODE);
    chkPins(1'b0, Pat);
    summarize();
  end
endmodule
